// ### logic/stxl_pkg.sv
package stxl_pkg;

    // =========================================================================
    // Geometry
    // =========================================================================
    localparam int NUM_INST = 16;
    localparam int INST_W = 4;
    localparam int LANE_W = 4;
    localparam int LANES = 16;
    localparam int VOLT_W = 5;
    localparam int DEEMPH_W = 3;

    // =========================================================================
    // Register map (byte addresses)
    // =========================================================================
    localparam logic [11:0] TXLC_BASE = 12'h000;
    localparam logic [11:0] SDCTL_ADDR = 12'h040;
    localparam logic [11:0] LANECFG_ADDR = 12'h044;
    localparam logic [11:0] ADDR_MASK = 12'hFFF;

    // =========================================================================
    // Lane level control field layout
    // =========================================================================
    localparam int VOLT_R1_LSB = 0;
    localparam int DE35_R1_LSB = 5;
    localparam int VOLT35_R2_LSB = 8;
    localparam int DE35_R2_LSB = 13;
    localparam int VOLT60_R2_LSB = 16;
    localparam logic [31:0] TXLC_RW_MASK = 32'h001FFFFF;

    // =========================================================================
    // Reset values
    // =========================================================================
    localparam logic [4:0] VOLT_R1_RST = 5'h11;
    localparam logic [2:0] DE35_R1_RST = 3'h4;
    localparam logic [4:0] VOLT35_R2_RST = 5'h17;
    localparam logic [2:0] DE35_R2_RST = 3'h4;
    localparam logic [4:0] VOLT60_R2_RST = 5'h13;
    localparam logic [2:0] DE60_R2_DEFAULT = 3'h2;

    // =========================================================================
    // Companion control layout
    // =========================================================================
    localparam int LANE_SELECTOR_LSB = 0;
    localparam int CFG_RATE2_LSB = 0;
    localparam int CFG_DE60_LSB = 16;

endpackage : stxl_pkg

// ### logic/stxl_bank.sv
// Summary of operation
// - Sixteen lane copies, indexed zero to fifteen.
// - Bits 4:0 rate-one voltage, reset 0x11.
// - Bits 7:5 rate-one fine de-emphasis, reset 0x4.
// - Bits 12:8 rate-two -3.5 dB voltage, reset 0x17.
// - Bits 15:13 rate-two -3.5 dB de-emphasis, reset 0x4.
// - Bits 20:16 rate-two -6.0 dB voltage, reset 0x13.
// - Low swing ignores both fine de-emphasis codes.
// - Voltage codes pass unchanged to driver.
// - Writes reach only lane_selector chosen lane.
// - Every lane keeps its level codes across ordinary resets; its rate two, -6.0 dB and low swing bits clear.
// - Low swing exactly when low_swing_enable is one.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module stxl_bank (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Ordinary (hot) reset; sticky fields ignore it
    input wire logic soft_rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Per-lane driver codes
    output logic [79:0] drv_volt,
    output logic [47:0] drv_deemph
);

    // =========================================================================
    // Storage
    // =========================================================================
    logic [4:0] volt_r1_r [16];
    logic [2:0] de35_r1_r [16];
    logic [4:0] volt35_r2_r [16];
    logic [2:0] de35_r2_r [16];
    logic [4:0] volt60_r2_r [16];
    logic [4:0] volt_r1_nxt [16];
    logic [2:0] de35_r1_nxt [16];
    logic [4:0] volt35_r2_nxt [16];
    logic [2:0] de35_r2_nxt [16];
    logic [4:0] volt60_r2_nxt [16];
    logic [3:0] lane_selector_r, lane_selector_nxt;
    logic [15:0] rate2_r, rate2_nxt;
    logic [15:0] de60_r, de60_nxt;
    logic [15:0] low_swing_enable_r, low_swing_enable_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [79:0] drv_volt_r, drv_volt_nxt;
    logic [47:0] drv_deemph_r, drv_deemph_nxt;

    function automatic logic is_txlc(input logic [11:0] a);
        is_txlc = (a[11:6] == stxl_pkg::TXLC_BASE[11:6]) && (a[1:0] == 2'h0);
    endfunction : is_txlc

    logic access, wr;
    logic [3:0] idx;
    assign access = psel && penable && !pready_r;
    assign wr = access && pwrite;
    assign idx = paddr[5:2];

    // =========================================================================
    // Next-state
    // =========================================================================
    always_comb begin
        volt_r1_nxt = volt_r1_r;
        de35_r1_nxt = de35_r1_r;
        volt35_r2_nxt = volt35_r2_r;
        de35_r2_nxt = de35_r2_r;
        volt60_r2_nxt = volt60_r2_r;
        lane_selector_nxt = lane_selector_r;
        rate2_nxt = rate2_r;
        de60_nxt = de60_r;
        low_swing_enable_nxt = low_swing_enable_r;
        prdata_nxt = prdata_r;
        pready_nxt = access;
        pslverr_nxt = 1'b0;
        if (access) begin
            prdata_nxt = 32'h00000000;
            if (is_txlc(paddr)) begin
                // Address index picks the instance; its lane is lane_selector.
                if (wr && (idx == lane_selector_r)) begin
                    volt_r1_nxt[idx] = pwdata[stxl_pkg::VOLT_R1_LSB +: 5];
                    de35_r1_nxt[idx] = pwdata[stxl_pkg::DE35_R1_LSB +: 3];
                    volt35_r2_nxt[idx] = pwdata[stxl_pkg::VOLT35_R2_LSB +: 5];
                    de35_r2_nxt[idx] = pwdata[stxl_pkg::DE35_R2_LSB +: 3];
                    volt60_r2_nxt[idx] = pwdata[stxl_pkg::VOLT60_R2_LSB +: 5];
                end
                prdata_nxt = {11'h000, volt60_r2_r[idx], de35_r2_r[idx], volt35_r2_r[idx],
                              de35_r1_r[idx], volt_r1_r[idx]};
            end else if (paddr == stxl_pkg::SDCTL_ADDR) begin
                if (wr) begin
                    lane_selector_nxt = pwdata[stxl_pkg::LANE_SELECTOR_LSB +: 4];
                end
                prdata_nxt = {28'h0000000, lane_selector_r};
            end else if (paddr == stxl_pkg::LANECFG_ADDR) begin
                // Per lane: rate two, -6.0 dB select, low_swing_enable. Selected lane only.
                if (wr) begin
                    rate2_nxt[lane_selector_r] = pwdata[stxl_pkg::CFG_RATE2_LSB];
                    de60_nxt[lane_selector_r] = pwdata[stxl_pkg::CFG_RATE2_LSB + 1];
                    low_swing_enable_nxt[lane_selector_r] = pwdata[stxl_pkg::CFG_RATE2_LSB + 2];
                end
                prdata_nxt = {29'h00000000, low_swing_enable_r[lane_selector_r],
                              de60_r[lane_selector_r], rate2_r[lane_selector_r]};
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // Driver selection; low swing voltages are outside this bank, so full-swing codes stand in.
    always_comb begin
        for (int i = 0; i < stxl_pkg::LANES; i++) begin
            if (!rate2_r[i]) begin
                drv_volt_nxt[i*5 +: 5] = volt_r1_r[i];
                drv_deemph_nxt[i*3 +: 3] = de35_r1_r[i];
            end else if (de60_r[i]) begin
                drv_volt_nxt[i*5 +: 5] = volt60_r2_r[i];
                drv_deemph_nxt[i*3 +: 3] = stxl_pkg::DE60_R2_DEFAULT;
            end else begin
                drv_volt_nxt[i*5 +: 5] = volt35_r2_r[i];
                drv_deemph_nxt[i*3 +: 3] = de35_r2_r[i];
            end
            if (low_swing_enable_r[i]) begin
                drv_deemph_nxt[i*3 +: 3] = 3'h0;
            end
        end
    end

    // =========================================================================
    // Registers: only power-on reset loads the lane code reset values; soft_rst_n also clears selector and lane config.
    // =========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < stxl_pkg::NUM_INST; i++) begin
                volt_r1_r[i] <= stxl_pkg::VOLT_R1_RST;
                de35_r1_r[i] <= stxl_pkg::DE35_R1_RST;
                volt35_r2_r[i] <= stxl_pkg::VOLT35_R2_RST;
                de35_r2_r[i] <= stxl_pkg::DE35_R2_RST;
                volt60_r2_r[i] <= stxl_pkg::VOLT60_R2_RST;
            end
            lane_selector_r <= 4'h0;
            rate2_r <= 16'h0000;
            de60_r <= 16'h0000;
            low_swing_enable_r <= 16'h0000;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            drv_volt_r <= 80'h0;
            drv_deemph_r <= 48'h0;
        end else begin
            volt_r1_r <= volt_r1_nxt;
            de35_r1_r <= de35_r1_nxt;
            volt35_r2_r <= volt35_r2_nxt;
            de35_r2_r <= de35_r2_nxt;
            volt60_r2_r <= volt60_r2_nxt;
            lane_selector_r <= soft_rst_n ? lane_selector_nxt : 4'h0;
            rate2_r <= soft_rst_n ? rate2_nxt : 16'h0000;
            de60_r <= soft_rst_n ? de60_nxt : 16'h0000;
            low_swing_enable_r <= soft_rst_n ? low_swing_enable_nxt : 16'h0000;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            drv_volt_r <= drv_volt_nxt;
            drv_deemph_r <= drv_deemph_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drv_volt = drv_volt_r;
    assign drv_deemph = drv_deemph_r;

endmodule : stxl_bank

`default_nettype wire

// ### tb/stxl_bank_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bus timing and driver code checks
module stxl_bank_chk (
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Driver codes
    input wire logic [79:0] drv_volt,
    input wire logic [47:0] drv_deemph
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    access_answer_a: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    unmapped_err_a: assert property (psel && $rose(penable) && paddr > 12'h044 |=> pslverr) else $error("no error");
    lane_defaults_a: assert property ($rose(presetn) |=> drv_volt[79:75] == 5'h11 && drv_deemph[2:0] == 3'h4)
        else $error("bad default codes");
    code_cause_a: assert property ($changed({drv_volt, drv_deemph}) |->
        $past(psel && penable && pwrite, 2) || $past(!soft_rst_n, 2) || $past(!presetn, 2)) else $error("stray change");
    mapped_ok_a: assert property (psel && $rose(penable) && (paddr < 12'h040 || paddr == 12'h040 || paddr == 12'h044)
        && paddr[1:0] == 2'h0 |=> !pslverr) else $error("bad error");
    cover property (pslverr);
    cover property (pready && pwrite);
    cover property ($fell(soft_rst_n));
endmodule : stxl_bank_chk
bind stxl_bank stxl_bank_chk chk_u (.pclk(pclk), .presetn(presetn), .soft_rst_n(soft_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drv_volt(drv_volt), .drv_deemph(drv_deemph));
`default_nettype wire

// ### tb/test_stxl_bank.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Level bank bench against a queue-free model
module test_stxl_bank;
    logic pclk = 1'b0, presetn = 1'b0, soft_rst_n = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, lf;
    logic pready, pslverr, er;
    logic [79:0] drv_volt;
    logic [47:0] drv_deemph;
    logic [20:0] m_reg [16];
    logic [2:0] m_cfg [16];
    logic [3:0] m_sel;
    int error_cnt, checked, cyc;
    stxl_bank dut_u (.pclk(pclk), .presetn(presetn), .soft_rst_n(soft_rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drv_volt(drv_volt), .drv_deemph(drv_deemph));
    initial begin
        forever #20 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task test_done;
        $display("Compares %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    // Read data and the error flag are taken at the rising edge that sees pready high, then released.
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] exp;
        exp = a > 12'h044 ? 32'h0 : a < 12'h040 ? {11'h0, m_reg[a[5:2]]} : a == 12'h040 ? {28'h0, m_sel} :
            {29'h0, m_cfg[m_sel]};
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a < 12'h040 && a[5:2] == m_sel) m_reg[a[5:2]] = d[20:0];
        if (w && a == 12'h040) m_sel = d[3:0];
        if (w && a == 12'h044) m_cfg[m_sel] = d[2:0];
        if (!w) chk(rd, exp);
        chk({31'h0, er}, {31'h0, a > 12'h044});
    endtask : bus
    task drv_chk;
        logic [20:0] r;
        logic [2:0] c;
        repeat (3) @(negedge pclk);
        for (int i = 0; i < 16; i++) begin
            r = m_reg[i];
            c = m_cfg[i];
            chk({27'h0, drv_volt[5*i+:5]}, {27'h0, c[0] ? (c[1] ? r[20:16] : r[12:8]) : r[4:0]});
            chk({29'h0, drv_deemph[3*i+:3]}, {29'h0, c[2] ? 3'h0 : c[0] ? (c[1] ? 3'h2 : r[15:13]) : r[7:5]});
        end
    endtask : drv_chk
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        lf = 32'h6D2E;
        m_sel = 4'h0;
        for (int i = 0; i < 16; i++) begin
            m_reg[i] = 21'h139791;
            m_cfg[i] = 3'h0;
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        drv_chk();
        for (int n = 0; n < 16; n++) bus(1'b0, 12'(4 * n), 32'h0);
        for (int n = 0; n < 16; n++) begin
            lf = nxt(lf);
            bus(1'b1, 12'h040, {lf[31:4], 4'(n)});
            bus(1'b1, 12'(4 * n), lf);
            bus(1'b1, 12'(4 * ((n + 1) % 16)), ~lf);
            bus(1'b1, 12'h044, {lf[31:3], 3'(n)});
            bus(1'b0, 12'h044, 32'h0);
            bus(1'b0, 12'(4 * n), 32'h0);
        end
        drv_chk();
        bus(1'b0, 12'h048, 32'h0);
        bus(1'b1, 12'hFFC, 32'hFFFFFFFF);
        soft_rst_n <= 1'b0;
        @(posedge pclk);
        soft_rst_n <= 1'b1;
        m_sel = 4'h0;
        for (int i = 0; i < 16; i++) m_cfg[i] = 3'h0;
        drv_chk();
        for (int n = 0; n < 16; n++) bus(1'b0, 12'(4 * n), 32'h0);
        bus(1'b0, 12'h040, 32'h0);
        test_done();
    end
endmodule : test_stxl_bank
`default_nettype wire
